// ===== pkg/spfl_map.svh
/*
  Constants of the serial flash lane interface: timing counts and fixed
  values shared by the design files.
  Assumes the system clock runs at the rate given below.
*/
`ifndef SPFL_MAP_SVH
`define SPFL_MAP_SVH

// System clock rate in MHz.
`define SPFL_CLK_MHZ 250
// Least low time of the hardware reset pin, in ns.
`define SPFL_RST_MIN_NS 1000
// Least low time in clock cycles, rounded up.
`define SPFL_RST_CYC ((`SPFL_RST_MIN_NS * `SPFL_CLK_MHZ + 999) / 1000)
// Width of the reset low-time counter.
`define SPFL_CNT_W 9
// Byte shifted out when no new output byte was posted.
`define SPFL_IDLE_BYTE 8'hFF
// Bits in one byte.
`define SPFL_BYTE_BITS 4'h8
// Bits moved per clock edge in each lane mode.
`define SPFL_STEP_SINGLE 4'h1
`define SPFL_STEP_DUAL 4'h2
`define SPFL_STEP_QUAD 4'h4

`endif

// ===== pkg/spfl_pkg.sv
/*
  Types of the serial flash lane interface.
  Assumes nothing of its surroundings.
*/
package spfl_pkg;

  // Lane width used for a phase of an instruction.
  typedef enum logic [1:0] {
    SPFL_SINGLE = 2'h0,
    SPFL_DUAL   = 2'h1,
    SPFL_QUAD   = 2'h2
  } spfl_lane_e;

  // States of the hardware reset pin filter.
  typedef enum logic [2:0] {
    RST_RUN  = 3'h1,
    RST_LOW  = 3'h2,
    RST_HELD = 3'h4
  } spfl_rst_e;

endpackage

// ===== rtl/spfl_lane_if.sv
/*
  Pin lane interface of a serial flash device: chip select, lane
  direction, single, dual and quad shifting, hold, write protect and
  hardware reset filtering.
  Assumes a host that makes spi_clk, drives inputs for rising edges and
  samples outputs after falling edges; the user side runs on mclk.
*/
// What this block does
// - Deselected device keeps every lane undriven.
// - Selected device takes bytes and returns data.
// - Ignore instructions until first select falling edge.
// - Single mode samples serial input on rising edge.
// - Single mode shifts output on falling edge.
// - Dual and quad lanes bidirectional, same edges.
// - Quad phases run only with quad enable set.
// - Quad enable turns protect, hold into lanes.
// - Single, dual use lanes 0,1; quad all.
// - Hold works only outside quad operation.
// - Hardware reset acts whatever the state.
// - Internal operations continue after deselect.
// - Hold low tristates output and freezes shifting.
// - Reset pin low one microsecond resets device.
// - Clock modes 0 and 3 both work.
`include "spfl_map.svh"
module spfl_lane_if
  import spfl_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic        spi_clk,
  input  wire logic        sel_n,
  input  wire logic        hw_reset_n,
  input  wire logic        lane_zero_i,
  output logic             lane_zero_o,
  output logic             lane_zero_oe,
  input  wire logic        lane_one_i,
  output logic             lane_one_o,
  output logic             lane_one_oe,
  input  wire logic        lane_two_i,
  output logic             lane_two_o,
  output logic             lane_two_oe,
  input  wire logic        lane_three_i,
  output logic             lane_three_o,
  output logic             lane_three_oe,
  input  wire logic        quad_lane_enable,
  input  wire logic        op_busy,
  input  wire logic        ph_valid,
  input  wire logic        ph_dir,
  input  wire spfl_lane_e  ph_mode,
  input  wire logic [7:0]  ph_byte,
  output logic             ph_ready,
  output logic             quad_refused,
  output logic [7:0]       rx_byte,
  output logic             rx_valid,
  output logic             selected,
  output logic             frame_start,
  output logic             frame_end,
  output logic             standby,
  output logic             write_protect,
  output logic             dev_reset
);

  localparam int RST_CYC_I = `SPFL_RST_CYC;
  localparam logic [`SPFL_CNT_W-1:0] RST_LAST =
    `SPFL_CNT_W'(`SPFL_RST_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  // Crossings.

  logic [4:0] m_async;   // Levels entering the mclk domain.
  logic [4:0] m_sync;    // Their synchronised copies.
  logic [1:0] l_async;   // Levels entering the spi_clk domain.
  logic [1:0] l_sync;    // Their synchronised copies.
  logic       cs_s;      // Chip select, high while deselected.
  logic       rst_s;     // Hardware reset pin, low while asserted.
  logic       wp_s;      // Write protect pin, low while protecting.
  logic       rx_tog_s;  // Received byte event, toggle form.
  logic       ack_s;     // Phase word taken, toggle form.
  logic       qe_l;      // Quad enable as seen by the link.
  logic       ph_tog_l;  // Phase word posted, as seen by the link.
  logic       rx_tog;    // Link flips this per received byte.
  logic       ack_tog;   // Link flips this per phase word taken.
  logic       ph_tog;    // User side flips this per posted word.

  assign m_async  = {ack_tog, rx_tog, lane_two_i, hw_reset_n, sel_n};
  assign cs_s     = m_sync[0];
  assign rst_s    = m_sync[1];
  assign wp_s     = m_sync[2];
  assign rx_tog_s = m_sync[3];
  assign ack_s    = m_sync[4];
  assign l_async  = {ph_tog, quad_lane_enable};
  assign qe_l     = l_sync[0];
  assign ph_tog_l = l_sync[1];

  // One synchroniser per level; the mclk ones freeze with the enable.
  for (genvar i = 0; i < 5; i++) begin : g_msync
    spfl_sync u_sync (
      .clk (mclk),
      .en  (ce),
      .d   (m_async[i]),
      .q   (m_sync[i])
    );
  end
  for (genvar i = 0; i < 2; i++) begin : g_lsync
    spfl_sync u_sync (
      .clk (spi_clk),
      .en  (1'b1),
      .d   (l_async[i]),
      .q   (l_sync[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Hardware reset pin filter.

  spfl_rst_e              rst_st;   // Filter state.
  logic [`SPFL_CNT_W-1:0] rst_cnt;  // Cycles seen low so far.
  logic [`SPFL_CNT_W-1:0] low_len;  // Check helper: low run length.
  logic                   link_rst; // Clears the link logic.

  // A short glitch is dropped; only a long low resets the device.
  // acts in any state
  always_ff @(posedge mclk) begin
    if (srst) begin
      rst_st    <= RST_RUN;
      rst_cnt   <= '0;
      dev_reset <= 1'b0;
    end else if (ce) begin
      case (rst_st)
        RST_RUN: begin
          rst_cnt <= '0;
          if (!rst_s) begin
            rst_st <= RST_LOW;
          end
        end
        RST_LOW: begin
          if (rst_s) begin
            rst_st <= RST_RUN;
          end else if (rst_cnt == RST_LAST) begin
            rst_st    <= RST_HELD;
            dev_reset <= 1'b1;
          end else begin
            rst_cnt <= rst_cnt + 1'b1;
          end
        end
        RST_HELD: begin
          if (rst_s) begin
            rst_st    <= RST_RUN;
            dev_reset <= 1'b0;
          end
        end
        default: begin
          rst_st <= RST_RUN;
        end
      endcase
    end
  end

  // The link is cleared by a system reset or a hardware reset.
  always_ff @(posedge mclk) begin
    if (srst) begin
      link_rst <= 1'b1;
    end else if (ce) begin
      link_rst <= dev_reset;
    end
  end

  // Counts the current low run of the pin, saturating.
  always_ff @(posedge mclk) begin
    if (srst || rst_s) begin
      low_len <= '0;
    end else if (ce && low_len != '1) begin
      low_len <= low_len + 1'b1;
    end
  end

  AST_RESET_LONG: assert property (
    @(posedge mclk) disable iff (srst)
    $rose(dev_reset) |-> low_len >= RST_CYC_I)
    else $error("Device reset after too short a low pulse.");

  ////////////////////////////////////////////////////////////////////////
  // Selection tracking, user side.

  logic cs_d;     // Delayed chip select for edge detection.
  logic armed;    // A select falling edge has been seen.
  logic sel_fall; // Select went active.
  logic sel_rise; // Select went inactive.

  assign sel_fall = cs_d & ~cs_s;
  assign sel_rise = ~cs_d & cs_s;

  // A frame already running at reset release is armed, since cs_d resets high.
  // arm on falling edge
  always_ff @(posedge mclk) begin
    if (srst) begin
      cs_d          <= 1'b1;
      armed         <= 1'b0;
      frame_start   <= 1'b0;
      frame_end     <= 1'b0;
      selected      <= 1'b0;
      standby       <= 1'b1;
      write_protect <= 1'b0;
    end else if (ce) begin
      cs_d        <= cs_s;
      frame_start <= sel_fall & ~dev_reset;
      frame_end   <= sel_rise;
      if (dev_reset) begin
        armed <= 1'b0;
      end else if (sel_fall) begin
        armed <= 1'b1;
      end
      selected      <= ~cs_s & armed & ~dev_reset;
      standby       <= cs_s & ~op_busy;
      write_protect <= ~quad_lane_enable & ~wp_s;
    end
  end

  AST_ARM_ON_FALL: assert property (
    @(posedge mclk) disable iff (srst)
    $rose(armed) |-> $past(sel_fall))
    else $error("Armed without a select falling edge.");

  AST_RESET_DISARM: assert property (
    @(posedge mclk) disable iff (srst)
    (dev_reset && ce) |=> !armed && !selected)
    else $error("Still selected during hardware reset.");

  ////////////////////////////////////////////////////////////////////////
  // Received bytes, user side.

  logic [7:0] rx_hold; // Link copy of the last byte.
  logic       rx_seen; // Last toggle value taken.

  // The link keeps rx_hold still for two lane clocks after the toggle,
  // far longer than the three mclk cycles needed here.
  // deliver bytes
  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_seen  <= 1'b0;
      rx_byte  <= 8'h00;
      rx_valid <= 1'b0;
    end else if (ce) begin
      rx_valid <= 1'b0;
      if (rx_tog_s != rx_seen) begin
        rx_seen <= rx_tog_s;
        if (armed && !dev_reset) begin
          rx_byte  <= rx_hold;
          rx_valid <= 1'b1;
        end
      end
    end
  end

  sequence s_rx_event;
    ce && armed && !dev_reset && (rx_tog_s != rx_seen);
  endsequence

  AST_RX_DELIVER: assert property (
    @(posedge mclk) disable iff (srst)
    s_rx_event |=> rx_valid && rx_byte == $past(rx_hold))
    else $error("Received byte not delivered.");

  AST_RX_ARMED: assert property (
    @(posedge mclk) disable iff (srst)
    rx_valid |-> armed)
    else $error("Byte delivered before arming.");

  ////////////////////////////////////////////////////////////////////////
  // Phase words, user side.

  logic       post;      // A phase word is offered and accepted.
  logic       refuse;    // It asks for quad without quad enable.
  logic [7:0] ph_byte_q; // Held word: byte to send.
  logic       ph_dir_q;  // Held word: device drives.
  spfl_lane_e ph_mode_q; // Held word: lane mode.

  assign post   = ph_valid & ph_ready;
  assign refuse = post & (ph_mode == SPFL_QUAD) & ~quad_lane_enable;

  // The word stays still until the link acknowledges it.
  // refuse quad phases
  always_ff @(posedge mclk) begin
    if (srst) begin
      ph_tog       <= 1'b0;
      ph_ready     <= 1'b0;
      quad_refused <= 1'b0;
      ph_byte_q    <= 8'h00;
      ph_dir_q     <= 1'b0;
      ph_mode_q    <= SPFL_SINGLE;
    end else if (ce) begin
      quad_refused <= refuse & ~dev_reset;
      if (dev_reset) begin
        ph_tog   <= 1'b0;
        ph_ready <= 1'b0;
      end else if (post && !refuse) begin
        ph_byte_q <= ph_byte;
        ph_dir_q  <= ph_dir;
        ph_mode_q <= ph_mode;
        ph_tog    <= ~ph_tog;
        ph_ready  <= 1'b0;
      end else begin
        ph_ready <= (ph_tog == ack_s) & ~link_rst;
      end
    end
  end

  AST_QUAD_REFUSE: assert property (
    @(posedge mclk) disable iff (srst)
    (ce && post && ph_mode == SPFL_QUAD && !quad_lane_enable
     && !dev_reset) |=> quad_refused && ph_tog == $past(ph_tog))
    else $error("Quad phase accepted without quad enable.");

  AST_POST_STALL: assert property (
    @(posedge mclk) disable iff (srst)
    (ce && post && !refuse && !dev_reset)
      |=> !ph_ready && ph_tog != $past(ph_tog))
    else $error("Phase word not held after posting.");

  ////////////////////////////////////////////////////////////////////////
  // Link logic on the lane clock.

  logic       frame_rst; // Clears frame state while deselected.
  logic       hold_act;  // Hold pin pauses the device.
  logic [3:0] step;      // Bits per edge.
  logic [7:0] rx_sh;     // Input shift register.
  logic [7:0] rx_next;   // Shift register after this edge.
  logic [3:0] bit_cnt;   // Bits of the current byte done.
  logic       byte_done; // This edge ends a byte.
  logic       take;      // This edge adopts a new phase word.
  spfl_lane_e mode_l;    // Lane mode in force.
  logic       dir_l;     // Device drives the lanes.
  logic [7:0] tx_word;   // Byte being shifted out.
  logic [7:0] tx_bits;   // Its bits still to go, top aligned.

  // Both clock modes work since only edges are used, never levels;
  // in mode 3 the first falling edge finds the lanes still inputs.
  // edge driven only
  assign frame_rst = sel_n | link_rst;
  assign hold_act  = ~qe_l & (mode_l != SPFL_QUAD) & ~lane_three_i;
  assign byte_done = (bit_cnt + step) == `SPFL_BYTE_BITS;
  assign take      = ~hold_act & byte_done & (ph_tog_l != ack_tog);
  assign tx_bits   = 8'(tx_word << bit_cnt);

  // Input lanes in use per mode.
  // single on serial input
  always_comb begin
    step    = `SPFL_STEP_SINGLE;
    rx_next = {rx_sh[6:0], lane_zero_i};
    case (mode_l)
      SPFL_DUAL: begin
        step    = `SPFL_STEP_DUAL;
        rx_next = {rx_sh[5:0], lane_one_i, lane_zero_i};
      end
      SPFL_QUAD: begin
        step    = `SPFL_STEP_QUAD;
        rx_next = {rx_sh[3:0], lane_three_i, lane_two_i,
                   lane_one_i, lane_zero_i};
      end
      default: begin
        step    = `SPFL_STEP_SINGLE;
        rx_next = {rx_sh[6:0], lane_zero_i};
      end
    endcase
  end

  // Rising edges sample lanes; hold freezes all frame state.
  // hold freezes shifting
  always_ff @(posedge spi_clk or posedge frame_rst) begin
    if (frame_rst) begin
      rx_sh   <= 8'h00;
      bit_cnt <= 4'h0;
      mode_l  <= SPFL_SINGLE;
      dir_l   <= 1'b0;
      tx_word <= `SPFL_IDLE_BYTE;
    end else if (!hold_act) begin
      rx_sh <= rx_next;
      if (byte_done) begin
        bit_cnt <= 4'h0;
        if (take) begin
          mode_l  <= ph_mode_q;
          dir_l   <= ph_dir_q;
          tx_word <= ph_byte_q;
        end else begin
          tx_word <= `SPFL_IDLE_BYTE;
        end
      end else begin
        bit_cnt <= bit_cnt + step;
      end
    end
  end

  // Toggles survive deselection so no event is lost or invented.
  always_ff @(posedge spi_clk or posedge link_rst) begin
    if (link_rst) begin
      rx_tog  <= 1'b0;
      ack_tog <= 1'b0;
      rx_hold <= 8'h00;
    end else begin
      if (take) begin
        ack_tog <= ~ack_tog;
      end
      if (!hold_act && byte_done && !dir_l) begin
        rx_hold <= rx_next;
        rx_tog  <= ~rx_tog;
      end
    end
  end

  // Falling edges drive lanes; the turn to output waits for one, so
  // the host has half a clock to let go of the shared lanes.
  // single on falling edge
  always_ff @(negedge spi_clk or posedge frame_rst) begin
    if (frame_rst) begin
      lane_zero_o   <= 1'b0;
      lane_zero_oe  <= 1'b0;
      lane_one_o    <= 1'b0;
      lane_one_oe   <= 1'b0;
      lane_two_o    <= 1'b0;
      lane_two_oe   <= 1'b0;
      lane_three_o  <= 1'b0;
      lane_three_oe <= 1'b0;
    end else if (hold_act || !dir_l) begin
      lane_zero_oe  <= 1'b0;
      lane_one_oe   <= 1'b0;
      lane_two_oe   <= 1'b0;
      lane_three_oe <= 1'b0;
    end else begin
      lane_zero_oe  <= mode_l != SPFL_SINGLE;
      lane_one_oe   <= 1'b1;
      lane_two_oe   <= mode_l == SPFL_QUAD;
      lane_three_oe <= mode_l == SPFL_QUAD;
      case (mode_l)
        SPFL_DUAL: begin
          {lane_one_o, lane_zero_o} <= tx_bits[7:6];
        end
        SPFL_QUAD: begin
          // protect and hold pins carry data
          {lane_three_o, lane_two_o, lane_one_o, lane_zero_o} <=
            tx_bits[7:4];
        end
        default: begin
          lane_one_o <= tx_bits[7];
        end
      endcase
    end
  end

  sequence s_last_bit;
    mode_l == SPFL_SINGLE && !dir_l && !hold_act && bit_cnt == 4'h7;
  endsequence

  AST_BYTE_SINGLE: assert property (
    @(posedge spi_clk) disable iff (frame_rst)
    s_last_bit |=> bit_cnt == 4'h0 && rx_tog != $past(rx_tog))
    else $error("Single lane byte not completed after eight bits.");

  AST_HOLD_FREEZE: assert property (
    @(posedge spi_clk) disable iff (frame_rst)
    hold_act |=> $stable(bit_cnt) && $stable(rx_sh))
    else $error("Shifting continued during hold.");

  AST_UPPER_LANES: assert property (
    @(posedge spi_clk) disable iff (frame_rst)
    mode_l != SPFL_QUAD |-> !lane_two_oe && !lane_three_oe)
    else $error("Upper lanes driven outside quad mode.");

  AST_SINGLE_LANE: assert property (
    @(posedge spi_clk) disable iff (frame_rst)
    mode_l == SPFL_SINGLE |-> !lane_zero_oe)
    else $error("Serial input lane driven in single mode.");

  AST_INPUT_UNDRIVEN: assert property (
    @(posedge spi_clk) disable iff (frame_rst)
    !dir_l |-> !(lane_zero_oe || lane_one_oe))
    else $error("Lanes driven during an input phase.");

  AST_DESEL_TRISTATE: assert property (
    @(posedge mclk) disable iff (srst)
    (ce && $past(ce) && $past(ce, 2) && cs_s && cs_d)
      |-> !(lane_zero_oe || lane_one_oe || lane_two_oe || lane_three_oe))
    else $error("Lane driven while deselected.");

endmodule // spfl_lane_if

// ===== rtl/spfl_sync.sv
/*
  Two flip-flop synchroniser for one level.
  Assumes the input is a level that stays long enough to be seen.
*/
module spfl_sync
  import spfl_pkg::*;
(
  input  wire logic clk,
  input  wire logic en,
  input  wire logic d,
  output logic      q
);

  logic meta; // First stage, read only by the second stage.

  // Both stages move together; the enable freezes them.
  always_ff @(posedge clk) begin
    if (en) begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // spfl_sync

// ===== sim/spfl_host.sv
/*
  Host controller model for the lane interface: makes the link clock in
  mode 0, drives chip select and the lanes that the host owns.
  Assumes the bench resolves each lane from both parties' enables.
*/
module spfl_host
  import spfl_pkg::*;
(
  output logic            spi_clk,
  output logic            sel_n,
  output logic      [3:0] h_oe,
  output logic      [3:0] h_d,
  input  wire logic [3:0] lane
);
  timeunit 1ns;
  timeprecision 1ps;

  // The link clock stands still and low outside frames.
  initial begin
    spi_clk = 1'b0;
    sel_n = 1'b1;
    h_oe = 4'h0;
    h_d = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // select fall: each frame opens with a fresh edge, clock low.
  task automatic open_frame();
    #1.3;
    sel_n = 1'b0;
    #15;
  endtask

  // mode zero: the clock is low again when select rises.
  task automatic close_frame();
    #15;
    sel_n = 1'b1;
    #30;
  endtask

  // Parks pins such as the protect lane at a level between frames.
  task automatic park(input logic [3:0] oe, input logic [3:0] d);
    h_oe = oe;
    h_d = d;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // transfer: data moves after a fall, is taken at a rise.
  task automatic xfer(input spfl_lane_e m, input logic dir,
                      input logic [7:0] tx, input int hold_at,
                      output logic [7:0] rx);
    int         w;
    int         n;
    logic [3:0] msk;
    w = (m == SPFL_QUAD) ? 4 : (m == SPFL_DUAL) ? 2 : 1;
    msk = 4'((1 << w) - 1);
    rx = 8'h00;
    for (n = 0; n < 8 / w; n++) begin
      // pause: hold low with junk on the data lane for two clocks.
      if (n == hold_at) begin
        h_oe[3] = 1'b1;
        h_d = {1'b0, ~h_d[2:0]};
        repeat (2) begin
          #15 spi_clk = 1'b1;
          #15 spi_clk = 1'b0;
        end
        // Hold is let go by the lane enables set just below.
      end
      h_oe = dir ? 4'h0 : msk;
      h_d = 4'(tx >> (8 - (n + 1) * w)) & msk;
      #15 spi_clk = 1'b1;
      rx = 8'((rx << w) | ((w == 1) ? 4'(lane[1]) : lane & msk));
      #5;
      // release: lanes are let go before the falling edge.
      if (n == 8 / w - 1) h_oe = 4'h0;
      #10 spi_clk = 1'b0;
    end
  endtask
endmodule // spfl_host

// ===== sim/tb.sv
/*
  Self-checking bench of the lane interface: host model on the link,
  phase words and an expected-byte queue on the mclk side.
  Assumes the design files and spfl_host are compiled before it.
*/
module tb
  import spfl_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic       mclk = 1'b0;
  logic       srst = 1'b1;
  logic       hw_reset_n = 1'b1;
  logic       ce = 1'b1;
  logic       qe = 1'b0;
  logic       op_busy = 1'b0;
  logic       ph_valid = 1'b0;
  logic       ph_dir = 1'b0;
  spfl_lane_e ph_mode = SPFL_SINGLE;
  logic [7:0] ph_byte = 8'h00;
  logic [7:0] seed = 8'h58;
  logic       spi_clk, sel_n, flt = 1'b0;
  wire logic [3:0] d_o, d_oe;
  logic [3:0] h_oe, h_d, lane;
  logic       ph_ready, quad_refused, rx_valid, selected, frame_start;
  logic       frame_end, standby, write_protect, dev_reset;
  logic [7:0] rx_byte;
  logic [7:0] got_q[$], exp_q[$];
  int         error_cnt = 0, n_compared = 0, n_ref = 0, n_rst = 0;
  int         n_fs = 0, n_fe = 0, nfr = 0, k;

  // Lane resolution: released lanes 2,3 pulled up, 0,1 wander.
  always #2 mclk = ~mclk;
  assign lane = (d_oe & d_o) | (~d_oe & h_oe & h_d)
              | (~d_oe & ~h_oe & {2'b11, flt, ~flt});

  spfl_host i_spfl_host (.spi_clk(spi_clk), .sel_n(sel_n), .h_oe(h_oe),
                         .h_d(h_d), .lane(lane));

  spfl_lane_if i_spfl_lane_if (
    .mclk(mclk), .srst(srst), .ce(ce), .spi_clk(spi_clk),
    .sel_n(sel_n), .hw_reset_n(hw_reset_n),
    .lane_zero_i(lane[0]), .lane_zero_o(d_o[0]), .lane_zero_oe(d_oe[0]),
    .lane_one_i(lane[1]), .lane_one_o(d_o[1]), .lane_one_oe(d_oe[1]),
    .lane_two_i(lane[2]), .lane_two_o(d_o[2]), .lane_two_oe(d_oe[2]),
    .lane_three_i(lane[3]), .lane_three_o(d_o[3]),
    .lane_three_oe(d_oe[3]), .quad_lane_enable(qe), .op_busy(op_busy),
    .ph_valid(ph_valid), .ph_dir(ph_dir), .ph_mode(ph_mode),
    .ph_byte(ph_byte), .ph_ready(ph_ready), .quad_refused(quad_refused),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .selected(selected),
    .frame_start(frame_start), .frame_end(frame_end), .standby(standby),
    .write_protect(write_protect), .dev_reset(dev_reset));

  // Collects one-cycle pulses so that none is missed between checks.
  always @(posedge mclk) begin
    flt <= ~flt;
    if (rx_valid === 1'b1) got_q.push_back(rx_byte);
    if (quad_refused === 1'b1) n_ref++;
    if (frame_start === 1'b1) n_fs++;
    if (frame_end === 1'b1) n_fe++;
    if (dev_reset === 1'b1) n_rst++;
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr_next();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Offers one phase word once ready is seen, under a bounded wait.
  task automatic post(input logic d, input spfl_lane_e m,
                      input logic [7:0] b);
    int i;
    for (i = 0; i < 500 && ph_ready !== 1'b1; i++) @(negedge mclk);
    if (i == 500) begin
      error_cnt++;
      stop_test();
    end
    @(negedge mclk);
    {ph_dir, ph_mode, ph_byte, ph_valid} = {d, m, b, 1'b1};
    @(negedge mclk);
    ph_valid = 1'b0;
  endtask

  // Instruction byte, then one phase byte in mode m, then for a read an idle byte.
  task automatic frame(input spfl_lane_e m, input logic dir, input int h);
    logic [7:0] ins, d, r;
    ins = lfsr_next();
    d = lfsr_next();
    got_q.delete();
    exp_q = {ins};
    if (!dir) exp_q.push_back(d);
    nfr++;
    i_spfl_host.open_frame();
    fork
      i_spfl_host.xfer(SPFL_SINGLE, 1'b0, ins, h, r);
      post(dir, m, d);
    join
    chk("selected", {7'h0, selected}, 8'h01);
    i_spfl_host.xfer(m, dir, d, -1, r);
    if (dir) begin
      chk("read byte", r, d);
      i_spfl_host.xfer(m, dir, 8'h00, -1, r);
      chk("idle byte", r, 8'hFF);
    end
    i_spfl_host.close_frame();
    chk("lanes off", {4'h0, d_oe}, 8'h00);
    repeat (10) @(negedge mclk);
    if (!dir) chk("rx count", 8'(got_q.size()), 8'h02);
    foreach (exp_q[i]) chk("rx byte", got_q[i], exp_q[i]);
    $display("frame mode %0d dir %0d done", m, dir);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end

  initial begin
    repeat (20) @(negedge mclk);
    srst = 1'b0;
    repeat (4) @(negedge mclk);
    chk("reset lanes", {4'h0, d_oe}, 8'h00);
    chk("standby", {7'h0, standby}, 8'h01);
    for (int m = 0; m < 2; m++)
      for (int d = 0; d < 2; d++) frame(spfl_lane_e'(m), d[0], 3);
    k = n_ref;
    post(1'b1, SPFL_QUAD, 8'hA5);
    repeat (4) @(negedge mclk);
    chk("quad refused", 8'(n_ref - k), 8'h01);
    chk("ready kept", {7'h0, ph_ready}, 8'h01);
    i_spfl_host.park(4'h4, 4'h0);
    repeat (8) @(negedge mclk);
    chk("protect", {7'h0, write_protect}, 8'h01);
    qe = 1'b1;
    repeat (8) @(negedge mclk);
    chk("protect", {7'h0, write_protect}, 8'h00);
    $display("refusal and protect done");
    i_spfl_host.park(4'h0, 4'h0);
    for (int m = 0; m < 3; m++)
      for (int d = 0; d < 2; d++) frame(spfl_lane_e'(m), d[0], -1);
    chk("frames", 8'(n_fs), 8'(nfr));
    chk("frame ends", 8'(n_fe), 8'(nfr));
    @(negedge mclk);
    {ce, op_busy} = 2'b01;
    repeat (6) @(negedge mclk);
    chk("standby frozen", {7'h0, standby}, 8'h01);
    ce = 1'b1;
    repeat (6) @(negedge mclk);
    chk("standby busy", {7'h0, standby}, 8'h00);
    op_busy = 1'b0;
    k = n_rst;
    hw_reset_n = 1'b0;
    repeat (100) @(negedge mclk);
    hw_reset_n = 1'b1;
    repeat (10) @(negedge mclk);
    chk("short reset", 8'(n_rst - k), 8'h00);
    $display("standby and short reset done");
    i_spfl_host.open_frame();
    @(negedge mclk);
    hw_reset_n = 1'b0;
    repeat (300) @(negedge mclk);
    chk("reset seen", {7'h0, dev_reset}, 8'h01);
    chk("reset lanes", {4'h0, d_oe}, 8'h00);
    $display("hardware reset done");
    hw_reset_n = 1'b1;
    i_spfl_host.close_frame();
    repeat (10) @(negedge mclk);
    frame(SPFL_QUAD, 1'b1, -1);
    stop_test();
  end
endmodule // tb
